/* logic/updown_panel_setting_counter.sv */
// Up/down pushbutton setting register, four BCD digits
//
// Behaviour
// - Short-press steps happen on button release, not press; repeat steps come while held
// - Short up press and release adds one
// - Short down press and release subtracts one
// - About one second held starts fast repeat
// - Beyond four seconds held, repeat goes faster
// - Wrap 9.999 to 0.000 and back
// - Both buttons together clear to zero
// - Release order after clear may step once
// - Value kept by battery, restored at power-up
`timescale 1ns/1ps
module updown_panel_setting_counter
   import panel_pkg::*;
#(
   parameter logic [31:0] DEB_CYC     = DEBOUNCE_CYC,
   parameter logic [31:0] HOLD1_CYC   = FAST_HOLD_CYC,
   parameter logic [31:0] HOLD2_CYC   = GEAR_HOLD_CYC,
   parameter logic [31:0] PERIOD1_CYC = FAST_PERIOD_CYC,
   parameter logic [31:0] PERIOD2_CYC = GEAR_PERIOD_CYC
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Panel pushbuttons, raw pins, high while pressed
   input  wire logic        up_btn,
   input  wire logic        dn_btn,
   // Battery-backed store of the last setting
   input  wire logic        bak_valid,
   input  wire logic [15:0] bak_bcd,
   // Setting towards the analog level circuitry
   output logic      [15:0] setting_bcd,
   output logic             changed
);

   // ------------------------------------------------------------
   // Button conditioning
   // ------------------------------------------------------------
   logic up_db;
   logic dn_db;

   button_conditioner #(.DEB_CYC(DEB_CYC)) u_up_cond (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .btn_raw   (up_btn),
      .btn_clean (up_db)
   );

   button_conditioner #(.DEB_CYC(DEB_CYC)) u_dn_cond (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .btn_raw   (dn_btn),
      .btn_clean (dn_db)
   );

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   btn_state_t  state_q;
   btn_state_t  state_d;
   logic [15:0] setting_q;
   logic [15:0] setting_d;
   logic [31:0] hold_q;
   logic [31:0] hold_d;
   logic [31:0] rep_q;
   logic [31:0] rep_d;
   logic        load_q;
   logic        changed_q;
   logic        changed_d;
   logic        step_en;
   logic        step_up;
   logic        repeating;
   logic [31:0] period;

   assign repeating = (hold_q >= HOLD1_CYC);
   assign period    = (hold_q >= HOLD2_CYC) ? PERIOD2_CYC
                                            : PERIOD1_CYC;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   // The hold counter saturates at the gear point so it never wraps
   // back into single-step behaviour during a very long hold.
   always_comb begin
      state_d   = state_q;
      hold_d    = hold_q;
      rep_d     = rep_q;
      step_en   = 1'b0;
      step_up   = 1'b1;
      setting_d = setting_q;
      changed_d = 1'b0;
      case (state_q)
         S_IDLE: begin
            hold_d = 32'h0;
            rep_d  = 32'h0;
            if (up_db && dn_db) begin
               state_d = S_BOTH;
            end else if (up_db) begin
               state_d = S_UP;
            end else if (dn_db) begin
               state_d = S_DN;
            end
         end
         S_UP, S_DN: begin
            step_up = (state_q == S_UP);
            if (up_db && dn_db) begin
               state_d = S_BOTH;
            end else if ((step_up && up_db) || (!step_up && dn_db)) begin
               if (hold_q < HOLD2_CYC) begin
                  hold_d = hold_q + 32'h1;
               end
               if (repeating) begin
                  step_en = (rep_q == 32'h0);
                  rep_d   = (rep_q >= period - 32'h1) ? 32'h0
                                                      : rep_q + 32'h1;
               end
            end else begin
               // Released: a short press counts once, a repeat does not
               state_d = S_IDLE;
               hold_d  = 32'h0;
               rep_d   = 32'h0;
               step_en = !repeating;
            end
         end
         S_BOTH: begin
            hold_d = 32'h0;
            rep_d  = 32'h0;
            if (up_db && !dn_db) begin
               state_d = S_UP;
            end else if (dn_db && !up_db) begin
               state_d = S_DN;
            end else if (!up_db && !dn_db) begin
               state_d = S_IDLE;
            end
         end
         default: begin
            state_d = S_IDLE;
            hold_d  = 32'h0;
            rep_d   = 32'h0;
         end
      endcase

      if (load_q) begin
         // Invalid backup contents fall back to zero
         setting_d = (bak_valid && bcd_valid(bak_bcd)) ? bak_bcd
                                                      : SETTING_RST;
      end else if (state_d == S_BOTH) begin
         setting_d = SETTING_RST;
      end else if (step_en) begin
         setting_d = bcd_step(setting_q, step_up);
      end
      changed_d = (setting_d != setting_q);
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q   <= S_IDLE;
         setting_q <= SETTING_RST;
         hold_q    <= 32'h0;
         rep_q     <= 32'h0;
         load_q    <= 1'b1;
         changed_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         setting_q <= setting_d;
         hold_q    <= hold_d;
         rep_q     <= rep_d;
         load_q    <= 1'b0;
         changed_q <= changed_d;
      end
   end

   assign setting_bcd = setting_q;
   assign changed     = changed_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence short_up_release;
      state_q == S_UP && !up_db && !dn_db && !repeating && !load_q;
   endsequence

   sequence short_dn_release;
      state_q == S_DN && !up_db && !dn_db && !repeating && !load_q;
   endsequence

   chk_press_no_step: assert property (
      @(posedge ref_clk) disable iff (rst)
      (state_q == S_IDLE && (up_db ^ dn_db) && !load_q)
      |=> $stable(setting_q))
      else $error("setting moved on button press");

   chk_up_single: assert property (
      @(posedge ref_clk) disable iff (rst)
      short_up_release |=> setting_q == bcd_step($past(setting_q), 1'b1)
                           ##1 $stable(setting_q))
      else $error("short up press did not add exactly one");

   chk_dn_single: assert property (
      @(posedge ref_clk) disable iff (rst)
      short_dn_release |=> setting_q == bcd_step($past(setting_q), 1'b0))
      else $error("short down press did not subtract one");

   chk_fast_start: assert property (
      @(posedge ref_clk) disable iff (rst)
      (state_q == S_UP && up_db && !dn_db && hold_q == HOLD1_CYC
       && rep_q == 32'h0 && !load_q)
      |=> setting_q == bcd_step($past(setting_q), 1'b1))
      else $error("repeat did not start after hold time");

   chk_gear_rate: assert property (
      @(posedge ref_clk) disable iff (rst)
      (hold_q >= HOLD2_CYC && state_q != S_IDLE && state_q != S_BOTH
       && $past(hold_q) >= HOLD2_CYC) |-> rep_q < PERIOD2_CYC)
      else $error("gear shift rate not applied");

   chk_wrap_up: assert property (
      @(posedge ref_clk) disable iff (rst)
      (short_up_release and (setting_q == SETTING_MAX))
      |=> setting_q == SETTING_RST)
      else $error("up count did not wrap to zero");

   chk_wrap_dn: assert property (
      @(posedge ref_clk) disable iff (rst)
      (short_dn_release and (setting_q == SETTING_RST))
      |=> setting_q == SETTING_MAX)
      else $error("down count did not wrap to maximum");

   chk_both_clear: assert property (
      @(posedge ref_clk) disable iff (rst)
      (up_db && dn_db && !load_q)
      |=> (setting_q == SETTING_RST && state_q == S_BOTH))
      else $error("both buttons did not clear setting");

   chk_clear_release: assert property (
      @(posedge ref_clk) disable iff (rst)
      (state_q == S_BOTH && up_db && !dn_db)
      |=> (state_q == S_UP && hold_q == 32'h0))
      else $error("release after clear not tracked");

   chk_restore: assert property (
      @(posedge ref_clk) disable iff (rst)
      (load_q && bak_valid && bcd_valid(bak_bcd))
      |=> setting_q == $past(bak_bcd))
      else $error("backup value not restored");

   chk_bcd_digits: assert property (
      @(posedge ref_clk) disable iff (rst)
      bcd_valid(setting_q))
      else $error("setting holds a non decimal digit");

endmodule : updown_panel_setting_counter

/* logic/panel_pkg.sv */
// Constants and helpers shared by the front-panel setting counter
package panel_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ          = 200_000_000;
   localparam int CYC_PER_MS      = CLK_HZ / 1000;
   localparam int DEBOUNCE_MS     = 10;
   localparam int FAST_HOLD_MS    = 1000;
   localparam int GEAR_HOLD_MS    = 4000;
   localparam int FAST_PERIOD_MS  = 100;
   localparam int GEAR_PERIOD_MS  = 20;

   localparam logic [31:0] DEBOUNCE_CYC    = 32'(DEBOUNCE_MS * CYC_PER_MS);
   localparam logic [31:0] FAST_HOLD_CYC   = 32'(FAST_HOLD_MS * CYC_PER_MS);
   localparam logic [31:0] GEAR_HOLD_CYC   = 32'(GEAR_HOLD_MS * CYC_PER_MS);
   localparam logic [31:0] FAST_PERIOD_CYC = 32'(FAST_PERIOD_MS * CYC_PER_MS);
   localparam logic [31:0] GEAR_PERIOD_CYC = 32'(GEAR_PERIOD_MS * CYC_PER_MS);

   // ------------------------------------------------------------
   // Setting values, four BCD digits
   // ------------------------------------------------------------
   localparam logic [15:0] SETTING_RST  = 16'h0000;
   localparam logic [15:0] SETTING_MAX  = 16'h9999;
   localparam logic [3:0]  DIGIT_MAX    = 4'h9;
   localparam int          DIGITS       = 4;

   // ------------------------------------------------------------
   // Button state machine, Gray ring
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_UP   = 2'b01,
      S_BOTH = 2'b11,
      S_DN   = 2'b10
   } btn_state_t;

   // One count up or down with digit carry and borrow; wraps both ends
   function automatic logic [15:0] bcd_step(input logic [15:0] v,
                                            input logic        up);
      logic [15:0] r;
      logic        c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < DIGITS; i++) begin
         if (c) begin
            if (up) begin
               if (v[4*i +: 4] >= DIGIT_MAX) begin
                  r[4*i +: 4] = 4'h0;
               end else begin
                  r[4*i +: 4] = v[4*i +: 4] + 4'h1;
                  c = 1'b0;
               end
            end else begin
               if (v[4*i +: 4] == 4'h0) begin
                  r[4*i +: 4] = DIGIT_MAX;
               end else begin
                  r[4*i +: 4] = v[4*i +: 4] - 4'h1;
                  c = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction : bcd_step

   function automatic logic bcd_valid(input logic [15:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < DIGITS; i++) begin
         if (v[4*i +: 4] > DIGIT_MAX) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : bcd_valid

endpackage : panel_pkg

/* logic/button_conditioner.sv */
// Two-flop synchroniser and debouncer for one panel pushbutton
`timescale 1ns/1ps
module button_conditioner
   import panel_pkg::*;
#(
   parameter logic [31:0] DEB_CYC = DEBOUNCE_CYC
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Raw pin and clean level
   input  wire logic btn_raw,
   output logic      btn_clean
);

   logic        sync1_q;
   logic        sync2_q;
   logic        db_q;
   logic        db_d;
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;

   // ------------------------------------------------------------
   // Debounce: level must stay put for the full count
   // ------------------------------------------------------------
   always_comb begin
      db_d  = db_q;
      cnt_d = 32'h0;
      if (sync2_q != db_q) begin
         if (cnt_q >= DEB_CYC - 32'h1) begin
            db_d = sync2_q;
         end else begin
            cnt_d = cnt_q + 32'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         db_q    <= 1'b0;
         cnt_q   <= 32'h0;
      end else begin
         sync1_q <= btn_raw;
         sync2_q <= sync1_q;
         db_q    <= db_d;
         cnt_q   <= cnt_d;
      end
   end

   assign btn_clean = db_q;

   chk_db_settled: assert property (
      @(posedge ref_clk) disable iff (rst)
      (db_q != $past(db_q)) |-> ($past(cnt_q) == DEB_CYC - 32'h1))
      else $error("debounced level changed before settling");

endmodule : button_conditioner

/* tb/panel_operator.sv */
// Operator model pressing and releasing the two panel pushbuttons
`timescale 1ns/1ps
module panel_operator (
   // Clock
   input  wire logic ref_clk,
   // Pushbutton pins, high while pressed
   output logic      up_btn,
   output logic      dn_btn
);
   initial begin
      up_btn = 1'b0;
      dn_btn = 1'b0;
   end

   // ------------------------------------------------------------
   // Contact action
   // ------------------------------------------------------------
   // Contacts chatter one cycle at a time, inside the debounce window,
   // so a clean design still sees a single press
   task automatic set_btn(input logic up, input logic lvl, input int chat);
      for (int i = chat; i >= 0; i--) begin
         @(negedge ref_clk);
         if (up) begin
            up_btn = i[0] ? ~lvl : lvl;
         end else begin
            dn_btn = i[0] ? ~lvl : lvl;
         end
      end
   endtask : set_btn
endmodule : panel_operator

/* tb/updown_panel_setting_counter_tb_top.sv */
// Self-checking bench for the up/down panel setting counter
`timescale 1ns/1ps
module updown_panel_setting_counter_tb_top;
   import panel_pkg::*;
   localparam logic [31:0] DEB = 32'h4;
   localparam logic [31:0] P1  = 32'h8;
   localparam logic [31:0] P2  = 32'h2;
   localparam int          SET = 16;

   logic        ref_clk, rst, bak_valid, changed;
   logic        up_btn, dn_btn;
   logic [15:0] bak_bcd, setting_bcd, prev_set;
   int          err_count, checked, cyc;
   int          ev_q[$];

   panel_operator panel_operator_inst (
      .ref_clk(ref_clk), .up_btn(up_btn), .dn_btn(dn_btn));

   updown_panel_setting_counter #(
      .DEB_CYC(DEB), .HOLD1_CYC(32'h28), .HOLD2_CYC(32'ha0),
      .PERIOD1_CYC(P1), .PERIOD2_CYC(P2)
   ) updown_panel_setting_counter_inst (
      .ref_clk(ref_clk), .rst(rst), .up_btn(up_btn), .dn_btn(dn_btn),
      .bak_valid(bak_valid), .bak_bcd(bak_bcd),
      .setting_bcd(setting_bcd), .changed(changed));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   always #2.5 ref_clk = ~ref_clk;

   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim

   function automatic logic [15:0] to_bcd(int n);
      return {4'(n / 1000 % 10), 4'(n / 100 % 10), 4'(n / 10 % 10),
              4'(n % 10)};
   endfunction : to_bcd

   task automatic wait_cyc(int n);
      repeat (n) @(negedge ref_clk);
   endtask : wait_cyc

   task automatic do_reset(logic [15:0] v, logic ok);
      @(negedge ref_clk);
      bak_valid = ok;
      bak_bcd   = v;
      rst       = 1'b1;
      wait_cyc(16);
      rst = 1'b0;
      wait_cyc(4);
      ev_q.delete();
   endtask : do_reset

   // Press, hold, release, then let debounce settle
   task automatic tap(logic up, int held);
      panel_operator_inst.set_btn(up, 1'b1, 3);
      wait_cyc(held);
      panel_operator_inst.set_btn(up, 1'b0, 3);
      wait_cyc(SET);
   endtask : tap

   // Setting and changed move together; doubles as the timeout
   always @(negedge ref_clk) begin
      cyc++;
      if (!rst) begin
         check("changed", {15'h0, changed},
               {15'h0, setting_bcd !== prev_set});
         if (changed === 1'b1) begin
            ev_q.push_back(cyc);
         end
      end
      prev_set = setting_bcd;
      if (cyc >= 20000) begin
         err_count++;
         end_sim();
      end
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_restore();
      do_reset(16'h1234, 1'b1);
      check("restored", setting_bcd, 16'h1234);
      do_reset(16'h12a4, 1'b1);
      check("bad store", setting_bcd, SETTING_RST);
      do_reset(16'h5678, 1'b0);
      check("no store", setting_bcd, SETTING_RST);
   endtask : t_restore

   task automatic t_short();
      do_reset(16'h0999, 1'b1);
      panel_operator_inst.set_btn(1'b1, 1'b1, 3);
      wait_cyc(20);
      check("while held", setting_bcd, 16'h0999);
      panel_operator_inst.set_btn(1'b1, 1'b0, 3);
      wait_cyc(SET);
      check("up step", setting_bcd, 16'h1000);
      tap(1'b0, 10);
      check("down step", setting_bcd, 16'h0999);
   endtask : t_short

   task automatic t_wrap();
      do_reset(SETTING_MAX, 1'b1);
      tap(1'b1, 10);
      check("overflow", setting_bcd, 16'h0000);
      tap(1'b0, 10);
      check("underflow", setting_bcd, SETTING_MAX);
      // A blip shorter than the debounce window is ignored
      panel_operator_inst.set_btn(1'b1, 1'b1, 0);
      wait_cyc(2);
      panel_operator_inst.set_btn(1'b1, 1'b0, 0);
      wait_cyc(SET);
      check("glitch", setting_bcd, SETTING_MAX);
   endtask : t_wrap

   task automatic t_hold();
      int n;
      int k;
      do_reset(16'h0000, 1'b1);
      panel_operator_inst.set_btn(1'b1, 1'b1, 3);
      wait_cyc(30);
      check("early repeat", 16'(ev_q.size()), 16'h0);
      wait_cyc(220);
      panel_operator_inst.set_btn(1'b1, 1'b0, 3);
      wait_cyc(SET);
      n = ev_q.size();
      if (n < 3) begin
         n = 3;
         check("repeats", 16'(ev_q.size()), 16'h3);
      end
      check("fast period", 16'(ev_q[1] - ev_q[0]), P1[15:0]);
      check("gear period", 16'(ev_q[n-1] - ev_q[n-2]), P2[15:0]);
      check("repeat total", setting_bcd, to_bcd(ev_q.size()));
      // Down hold stays inside the first rate; release adds no step
      k = ev_q.size();
      ev_q.delete();
      panel_operator_inst.set_btn(1'b0, 1'b1, 3);
      wait_cyc(60);
      panel_operator_inst.set_btn(1'b0, 1'b0, 3);
      wait_cyc(SET);
      check("down repeats", 16'(ev_q.size() >= 2), 16'h1);
      if (ev_q.size() >= 2) begin
         check("down period", 16'(ev_q[$] - ev_q[$-1]), P1[15:0]);
      end
      check("down total", setting_bcd, to_bcd(k - ev_q.size()));
   endtask : t_hold

   task automatic t_clear();
      do_reset(16'h0042, 1'b1);
      panel_operator_inst.set_btn(1'b1, 1'b1, 3);
      panel_operator_inst.set_btn(1'b0, 1'b1, 3);
      wait_cyc(SET);
      check("clear", setting_bcd, SETTING_RST);
      panel_operator_inst.set_btn(1'b0, 1'b0, 3);
      wait_cyc(SET);
      check("held clear", setting_bcd, SETTING_RST);
      panel_operator_inst.set_btn(1'b1, 1'b0, 3);
      wait_cyc(SET);
      check("after clear", setting_bcd, 16'h0001);
      // Down first, up released first: the down release borrows past zero
      panel_operator_inst.set_btn(1'b0, 1'b1, 3);
      panel_operator_inst.set_btn(1'b1, 1'b1, 3);
      wait_cyc(SET);
      check("clear down first", setting_bcd, SETTING_RST);
      panel_operator_inst.set_btn(1'b1, 1'b0, 3);
      wait_cyc(SET);
      check("held clear down", setting_bcd, SETTING_RST);
      panel_operator_inst.set_btn(1'b0, 1'b0, 3);
      wait_cyc(SET);
      check("down after clear", setting_bcd, SETTING_MAX);
   endtask : t_clear

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      ref_clk   = 1'b0;
      rst       = 1'b1;
      bak_valid = 1'b0;
      bak_bcd   = 16'h0000;
      prev_set  = 16'h0000;
      err_count = 0;
      checked   = 0;
      cyc       = 0;
      t_restore();
      t_short();
      t_wrap();
      t_hold();
      t_clear();
      end_sim();
   end
endmodule : updown_panel_setting_counter_tb_top
